// file: verilog/fomx_pkg.sv
package fomx_pkg;

   // command codes seen on the host write strobe
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_WORD_PGM_A = 8'h10;
   localparam logic [7:0] CMD_WORD_PGM_B = 8'h40;
   localparam logic [7:0] CMD_BUF_PGM_SETUP = 8'he8;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_FFP_SETUP = 8'h30;
   localparam logic [7:0] CMD_CONFIRM = 8'hd0;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY = 8'h98;
   localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
   localparam logic [7:0] CMD_OTP_SETUP = 8'hc0;
   localparam logic [7:0] CMD_LOCK_CONFIRM = 8'h01;
   localparam logic [7:0] CMD_LOCKDOWN_CONFIRM = 8'h2f;
   localparam logic [7:0] CMD_CONFIG_CONFIRM = 8'h03;

   // output multiplexer selection of one partition
   typedef enum logic [1:0] {
      SEL_ARRAY = 2'h0,
      SEL_ID = 2'h1,
      SEL_STATUS = 2'h2
   } fomx_sel_e;

   localparam fomx_sel_e SEL_RESET = SEL_ARRAY;

   // chip state group as given by the write sequencer
   typedef enum logic [3:0] {
      CLS_SETUP = 4'h1,
      CLS_LOCK_SETUP = 4'h2,
      CLS_OTP_BUSY = 4'h4,
      CLS_RUN = 4'h8
   } fomx_cls_e;

   typedef struct packed {
      fomx_cls_e cls;
      logic prog_susp;
      logic wsm_run;
      logic ffp_mode;
      logic ffp_busy;
      logic status_bit0;
      logic op_done;
   } fomx_chip_s;

   typedef struct packed {
      logic change;
      fomx_sel_e sel;
   } fomx_dec_s;

   typedef struct packed {
      logic clear_err;
      logic ffp_accept;
      logic ffp_discard;
      logic cmd_ignored;
      logic lock_go;
      logic illegal;
      logic first_cycle;
      logic blk_match;
   } fomx_ev_s;

   localparam fomx_ev_s EV_RESET = 8'h00;

endpackage

// file: verilog/fomx_part_sel.sv
`timescale 1ns/1ps
module fomx_part_sel (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // update
   input wire logic load,
   input fomx_pkg::fomx_sel_e sel_in,
   // held selection
   output fomx_pkg::fomx_sel_e sel
);

   typedef struct packed {
      fomx_pkg::fomx_sel_e sel;
   } fomx_ps_s;

   fomx_ps_s s_r;
   fomx_ps_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (load) begin
         s_nxt.sel = sel_in;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_r.sel <= fomx_pkg::SEL_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sel = s_r.sel;

endmodule // fomx_part_sel

// file: verilog/fomx_next_state.sv
// Overview of operation
// - In any setup, load, confirm or fast-factory-program state every command but an ignored confirm selects status; 03H in lock setup selects array.
// - From ready, suspend or busy, FFH selects array, 70H status, and 50H leaves it alone.
// - From ready, suspend or busy, every setup command switches the selection to status.
// - Codes outside the command set are illegal unless fast-factory-program is busy, and follow the illegal-command column.
// - While program is suspended, a confirm right after an erase setup is ignored.
// - Clear-status clears error bits only while the write sequencer is idle.
// - Fast-factory-program data is taken only while status bit 0 is 0 and its block matches the latched block, else discarded.
// - Each partition keeps the selection set by the last command that addressed it.
// - The selection decision depends only on chip state and command, never on a partition.
// - Lock, unlock, lock-down and config confirms run and then return the chip to ready.
// - The block address of the first cycle is latched and compared on later cycles.
`timescale 1ns/1ps
module fomx_next_state #(
   parameter int NPART = 8,
   parameter int BLK_W = 10
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // host command write
   input wire logic cmd_we,
   input wire logic [7:0] cmd_code,
   input wire logic [$clog2(NPART)-1:0] cmd_part,
   input wire logic [BLK_W-1:0] cmd_blk,
   // write sequencer state
   input fomx_pkg::fomx_chip_s chip,
   // per-partition output selection
   output fomx_pkg::fomx_sel_e [NPART-1:0] part_sel,
   // events, one cycle each
   output fomx_pkg::fomx_ev_s ev,
   // first-cycle block address
   output logic [BLK_W-1:0] first_cycle_block_address
);

   localparam int PART_W = $clog2(NPART);

   typedef struct packed {
      logic erase_after_psusp;
      logic [BLK_W-1:0] wa0;
      fomx_pkg::fomx_ev_s ev;
   } fomx_ns_s;

   fomx_ns_s s_r;
   fomx_ns_s s_nxt;

   logic [NPART-1:0] part_load;
   fomx_pkg::fomx_sel_e sel_new;
   fomx_pkg::fomx_dec_s dec;
   logic legal;
   logic two_cycle_setup;
   logic ignore_now;

   // membership in the accepted command set
   function automatic logic is_legal(input logic [7:0] code);
      logic r;
      r = 1'b0;
      case (code)
         fomx_pkg::CMD_READ_ARRAY,
         fomx_pkg::CMD_WORD_PGM_A,
         fomx_pkg::CMD_WORD_PGM_B,
         fomx_pkg::CMD_BUF_PGM_SETUP,
         fomx_pkg::CMD_ERASE_SETUP,
         fomx_pkg::CMD_FFP_SETUP,
         fomx_pkg::CMD_CONFIRM,
         fomx_pkg::CMD_SUSPEND,
         fomx_pkg::CMD_READ_STATUS,
         fomx_pkg::CMD_CLEAR_STATUS,
         fomx_pkg::CMD_READ_ID,
         fomx_pkg::CMD_READ_QUERY,
         fomx_pkg::CMD_LOCK_SETUP,
         fomx_pkg::CMD_OTP_SETUP,
         fomx_pkg::CMD_LOCK_CONFIRM,
         fomx_pkg::CMD_LOCKDOWN_CONFIRM,
         fomx_pkg::CMD_CONFIG_CONFIRM: begin
            r = 1'b1;
         end
         default: begin
            r = 1'b0;
         end
      endcase
      return r;
   endfunction

   // commands that open a multi-cycle operation
   function automatic logic is_setup(input logic [7:0] code);
      logic r;
      r = 1'b0;
      case (code)
         fomx_pkg::CMD_WORD_PGM_A,
         fomx_pkg::CMD_WORD_PGM_B,
         fomx_pkg::CMD_BUF_PGM_SETUP,
         fomx_pkg::CMD_ERASE_SETUP,
         fomx_pkg::CMD_FFP_SETUP,
         fomx_pkg::CMD_LOCK_SETUP,
         fomx_pkg::CMD_OTP_SETUP: begin
            r = 1'b1;
         end
         default: begin
            r = 1'b0;
         end
      endcase
      return r;
   endfunction

   // mux decision from chip state group and command only
   function automatic fomx_pkg::fomx_dec_s decide(
      input fomx_pkg::fomx_cls_e cls,
      input logic [7:0] code
   );
      fomx_pkg::fomx_dec_s d;
      d.change = 1'b1;
      d.sel = fomx_pkg::SEL_STATUS;
      case (cls)
         fomx_pkg::CLS_SETUP: begin
            d.change = 1'b1;
            d.sel = fomx_pkg::SEL_STATUS;
         end
         fomx_pkg::CLS_LOCK_SETUP: begin
            if (code == fomx_pkg::CMD_CONFIG_CONFIRM) begin
               d.sel = fomx_pkg::SEL_ARRAY;
            end else begin
               d.sel = fomx_pkg::SEL_STATUS;
            end
         end
         fomx_pkg::CLS_OTP_BUSY: begin
            d.sel = fomx_pkg::SEL_STATUS;
         end
         fomx_pkg::CLS_RUN: begin
            case (code)
               fomx_pkg::CMD_READ_ARRAY: begin
                  d.sel = fomx_pkg::SEL_ARRAY;
               end
               fomx_pkg::CMD_READ_STATUS: begin
                  d.sel = fomx_pkg::SEL_STATUS;
               end
               fomx_pkg::CMD_CLEAR_STATUS: begin
                  d.change = 1'b0;
               end
               fomx_pkg::CMD_WORD_PGM_A,
               fomx_pkg::CMD_WORD_PGM_B,
               fomx_pkg::CMD_BUF_PGM_SETUP,
               fomx_pkg::CMD_ERASE_SETUP,
               fomx_pkg::CMD_FFP_SETUP,
               fomx_pkg::CMD_LOCK_SETUP,
               fomx_pkg::CMD_OTP_SETUP: begin
                  d.sel = fomx_pkg::SEL_STATUS;
               end
               fomx_pkg::CMD_READ_ID,
               fomx_pkg::CMD_READ_QUERY: begin
                  d.sel = fomx_pkg::SEL_ID;
               end
               fomx_pkg::CMD_CONFIRM,
               fomx_pkg::CMD_SUSPEND,
               fomx_pkg::CMD_LOCK_CONFIRM,
               fomx_pkg::CMD_LOCKDOWN_CONFIRM,
               fomx_pkg::CMD_CONFIG_CONFIRM: begin
                  d.change = 1'b0;
               end
               default: begin
                  d.change = 1'b0;
               end
            endcase
         end
         default: begin
            d.change = 1'b0;
         end
      endcase
      return d;
   endfunction

   // decode of the current write
   always_comb begin
      legal = is_legal(cmd_code);
      two_cycle_setup = is_setup(cmd_code);
      dec = decide(chip.cls, cmd_code);
      // ambiguous erase-then-confirm while program is suspended
      ignore_now = chip.prog_susp && s_r.erase_after_psusp
         && (cmd_code == fomx_pkg::CMD_CONFIRM);
      sel_new = dec.sel;
   end

   // only the addressed partition takes the new selection
   genvar gi;
   generate
      for (gi = 0; gi < NPART; gi++) begin : g_part
         assign part_load[gi] = cmd_we && dec.change && !ignore_now
            && (cmd_part == PART_W'(gi));

         fomx_part_sel u_sel (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .load(part_load[gi]),
            .sel_in(sel_new),
            .sel(part_sel[gi])
         );
      end
   endgenerate

   // events and sequence memory
   always_comb begin
      s_nxt = s_r;
      s_nxt.ev = fomx_pkg::EV_RESET;
      if (cmd_we) begin
         s_nxt.ev.illegal = !legal && !chip.ffp_busy;
         s_nxt.ev.cmd_ignored = ignore_now;
         // erase setup under program suspend arms the ambiguity guard
         s_nxt.erase_after_psusp = chip.prog_susp
            && (chip.cls == fomx_pkg::CLS_RUN)
            && (cmd_code == fomx_pkg::CMD_ERASE_SETUP);

         if ((cmd_code == fomx_pkg::CMD_CLEAR_STATUS)
               && (chip.cls == fomx_pkg::CLS_RUN)
               && !chip.wsm_run && !chip.ffp_mode) begin
            s_nxt.ev.clear_err = 1'b1;
         end

         if (chip.ffp_busy) begin
            // data goes to the latched block only while bit 0 is clear
            if (!chip.status_bit0 && (cmd_blk == s_r.wa0)) begin
               s_nxt.ev.ffp_accept = 1'b1;
            end else begin
               s_nxt.ev.ffp_discard = 1'b1;
            end
         end

         if (chip.cls == fomx_pkg::CLS_LOCK_SETUP) begin
            case (cmd_code)
               fomx_pkg::CMD_LOCK_CONFIRM,
               fomx_pkg::CMD_LOCKDOWN_CONFIRM,
               fomx_pkg::CMD_CONFIRM,
               fomx_pkg::CMD_CONFIG_CONFIRM: begin
                  s_nxt.ev.lock_go = 1'b1;
               end
               default: begin
                  s_nxt.ev.lock_go = 1'b0;
               end
            endcase
         end

         if ((chip.cls == fomx_pkg::CLS_RUN) && two_cycle_setup && !ignore_now) begin
            s_nxt.wa0 = cmd_blk;
            s_nxt.ev.first_cycle = 1'b1;
         end else if (chip.cls != fomx_pkg::CLS_RUN) begin
            s_nxt.ev.blk_match = (cmd_blk == s_r.wa0);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_r.erase_after_psusp <= 1'b0;
         s_r.wa0 <= '0;
         s_r.ev <= fomx_pkg::EV_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ev = s_r.ev;
   assign first_cycle_block_address = s_r.wa0;

endmodule // fomx_next_state

// file: bench/fomx_next_state_asserts.sv
`timescale 1ns/1ps
module fomx_next_state_asserts #(
   parameter int NPART = 8,
   parameter int BLK_W = 10
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // host write
   input wire logic cmd_we,
   input wire logic [7:0] cmd_code,
   input wire logic [$clog2(NPART)-1:0] cmd_part,
   input wire logic [BLK_W-1:0] cmd_blk,
   input fomx_pkg::fomx_chip_s chip,
   // results
   input fomx_pkg::fomx_sel_e [NPART-1:0] part_sel,
   input fomx_pkg::fomx_ev_s ev,
   input wire logic [BLK_W-1:0] first_cycle_block_address
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic [3:0] cls;
   logic [1:0] sel;
   logic [$clog2(NPART)-1:0] pt_r;
   logic es_r;
   // group of the write, zero when no write
   assign cls = cmd_we ? chip.cls : 4'h0;
   assign sel = part_sel[pt_r];
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pt_r <= '0;
         es_r <= 1'b0;
      end else if (cmd_we) begin
         pt_r <= cmd_part;
         es_r <= cls == 4'h8 && chip.prog_susp && cmd_code == 8'h20;
      end
   end
   // an ignored confirm after erase setup under suspend keeps the selection
   property p_set;
      cls == 4'h1 && !(es_r && chip.prog_susp && cmd_code == 8'hd0) |=> sel == 2'h2;
   endproperty
   a_set: assert property (p_set) else $error("setup write kept no status");
   property p_ffh; cls == 4'h8 && cmd_code == 8'hff |=> sel == 2'h0; endproperty
   a_ffh: assert property (p_ffh) else $error("read array not selected");
   property p_keep; cls == 4'h8 && cmd_code inside {8'h50, [8'h04:8'h0f]} |=> $stable(part_sel);
   endproperty
   a_keep: assert property (p_keep) else $error("selection moved");
   property p_stat;
      cls == 4'h8 && cmd_code inside {8'h70, 8'h10, 8'h40, 8'he8, 8'h20, 8'h30, 8'h60, 8'hc0}
      |=> sel == 2'h2;
   endproperty
   a_stat: assert property (p_stat) else $error("status not selected");
   property p_ign; cls == 4'h8 && es_r && chip.prog_susp && cmd_code == 8'hd0
      |=> ev.cmd_ignored && $stable(first_cycle_block_address); endproperty
   a_ign: assert property (p_ign) else $error("confirm not ignored");
   property p_clr;
      1 |=> ev.clear_err == $past(cls == 4'h8 && cmd_code == 8'h50 && !chip.wsm_run && !chip.ffp_mode);
   endproperty
   a_clr: assert property (p_clr) else $error("clear status wrong");
   property p_ffp; cmd_we && chip.ffp_busy && chip.status_bit0 |=> ev.ffp_discard && !ev.ffp_accept;
   endproperty
   a_ffp: assert property (p_ffp) else $error("data not discarded");
   property p_lock; cls == 4'h2 && cmd_code inside {8'h01, 8'h2f, 8'hd0, 8'h03} |=> ev.lock_go;
   endproperty
   a_lock: assert property (p_lock) else $error("lock confirm not run");
   property p_lat; cls == 4'h8 && cmd_code == 8'h20
      |=> ev.first_cycle && first_cycle_block_address == $past(cmd_blk); endproperty
   a_lat: assert property (p_lat) else $error("address not latched");
   property p_idle; !cmd_we |=> $stable(part_sel); endproperty
   a_idle: assert property (p_idle) else $error("selection moved idle");
   c_lock: cover property (cls == 4'h2 ##1 ev.lock_go);
   c_ign: cover property (ev.cmd_ignored);
   c_ffp: cover property (ev.ffp_accept);
endmodule // fomx_next_state_asserts

bind fomx_next_state fomx_next_state_asserts #(.NPART(NPART), .BLK_W(BLK_W)) i_asserts (
   .sys_clk(sys_clk), .resetn(resetn), .cmd_we(cmd_we), .cmd_code(cmd_code),
   .cmd_part(cmd_part), .cmd_blk(cmd_blk), .chip(chip), .part_sel(part_sel), .ev(ev),
   .first_cycle_block_address(first_cycle_block_address));

// file: bench/fomx_host_model.sv
`timescale 1ns/1ps
module fomx_host_model #(
   parameter int NPART = 8,
   parameter int BLK_W = 10
) (
   // clock
   input wire logic sys_clk,
   // host write
   output logic cmd_we,
   output logic [7:0] cmd_code,
   output logic [$clog2(NPART)-1:0] cmd_part,
   output logic [BLK_W-1:0] cmd_blk,
   output fomx_pkg::fomx_chip_s chip
);
   initial begin
      cmd_we = 1'b0;
      cmd_code = 8'h00;
      cmd_part = '0;
      cmd_blk = '0;
      chip = '0;
   end
   // writes only; array data is never read back while busy
   task automatic write(input logic [7:0] c, input logic [$clog2(NPART)-1:0] p,
      input logic [BLK_W-1:0] b, input fomx_pkg::fomx_chip_s s);
      @(posedge sys_clk);
      #2;
      cmd_we = 1'b1;
      cmd_code = c;
      cmd_part = p;
      cmd_blk = b;
      chip = s;
   endtask
   // released code and block lines flip so a stale value is never taken for a write
   task automatic idle();
      @(posedge sys_clk);
      #2;
      cmd_we = 1'b0;
      cmd_code = ~cmd_code;
      cmd_blk = ~cmd_blk;
   endtask
endmodule // fomx_host_model

// file: bench/fomx_next_state_tb_top.sv
`timescale 1ns/1ps
module fomx_next_state_tb_top;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic cmd_we;
   logic [7:0] cmd_code;
   logic [1:0] cmd_part;
   logic [9:0] cmd_blk;
   logic [9:0] fa;
   logic [7:0] k;
   fomx_pkg::fomx_chip_s chip;
   fomx_pkg::fomx_ev_s ev;
   fomx_pkg::fomx_sel_e [3:0] part_sel;
   fomx_pkg::fomx_sel_e [3:0] exp;
   logic [7:0] cds [17] = '{8'hff, 8'h10, 8'h40, 8'he8, 8'h20, 8'h30, 8'hd0, 8'hb0, 8'h70,
      8'h50, 8'h90, 8'h98, 8'h60, 8'hc0, 8'h01, 8'h2f, 8'h03};
   logic es = 1'b0;
   int num_errors = 0;
   int checks = 0;
   always #12.5 sys_clk = ~sys_clk;
   fomx_host_model #(.NPART(4), .BLK_W(10)) i_fomx_host_model (.sys_clk(sys_clk),
      .cmd_we(cmd_we), .cmd_code(cmd_code), .cmd_part(cmd_part), .cmd_blk(cmd_blk), .chip(chip));
   fomx_next_state #(.NPART(4), .BLK_W(10)) i_fomx_next_state (.sys_clk(sys_clk),
      .resetn(resetn), .cmd_we(cmd_we), .cmd_code(cmd_code), .cmd_part(cmd_part),
      .cmd_blk(cmd_blk), .chip(chip), .part_sel(part_sel), .ev(ev),
      .first_cycle_block_address(fa));
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   function automatic fomx_pkg::fomx_sel_e nsel(input logic [3:0] c, input logic [7:0] k,
      input fomx_pkg::fomx_sel_e o);
      if (c == 4'h2) return k == 8'h03 ? fomx_pkg::SEL_ARRAY : fomx_pkg::SEL_STATUS;
      if (c != 4'h8) return fomx_pkg::SEL_STATUS;
      if (k == 8'hff) return fomx_pkg::SEL_ARRAY;
      if (k inside {8'h90, 8'h98}) return fomx_pkg::SEL_ID;
      if (k inside {8'h70, 8'h10, 8'h40, 8'he8, 8'h20, 8'h30, 8'h60, 8'hc0})
         return fomx_pkg::SEL_STATUS;
      return o;
   endfunction
   task automatic wr(input logic [7:0] k, input logic [1:0] p, input logic [9:0] b,
      input logic [3:0] c, input logic [5:0] f);
      i_fomx_host_model.write(k, p, b, fomx_pkg::fomx_chip_s'({c, f}));
      if (!(f[5] && es && k == 8'hd0)) exp[p] = nsel(c, k, exp[p]);
      es = f[5] && c == 4'h8 && k == 8'h20;
   endtask
   task automatic evt(input logic [7:0] k, input logic [1:0] p, input logic [9:0] b,
      input logic [3:0] c, input logic [5:0] f, input logic [7:0] m, input logic [7:0] e);
      wr(k, p, b, c, f);
      i_fomx_host_model.idle();
      check("ev", ev & m, e);
      check("sel", part_sel, exp);
   endtask
   initial begin
      #100000;
      num_errors++;
      summarize();
   end
   initial begin
      void'($urandom(11));
      foreach (exp[i]) exp[i] = fomx_pkg::SEL_ARRAY;
      repeat (4) @(posedge sys_clk);
      #2 resetn = 1'b1;
      check("sel", part_sel, exp);
      check("addr", fa, 10'h000);
      $display("test reset done");
      evt(8'h20, 2'h1, 10'h155, 4'h8, 6'h20, 8'h02, 8'h02);
      check("addr", fa, 10'h155);
      evt(8'hd0, 2'h1, 10'h0aa, 4'h8, 6'h20, 8'h10, 8'h10);
      check("addr", fa, 10'h155);
      evt(8'h20, 2'h1, 10'h0aa, 4'h8, 6'h00, 8'h02, 8'h02);
      evt(8'hd0, 2'h1, 10'h0aa, 4'h8, 6'h00, 8'h10, 8'h00);
      $display("test sequence done");
      evt(8'h50, 2'h3, 10'h001, 4'h8, 6'h00, 8'h80, 8'h80);
      evt(8'h50, 2'h3, 10'h001, 4'h8, 6'h10, 8'h80, 8'h00);
      evt(8'h50, 2'h3, 10'h001, 4'h8, 6'h08, 8'h80, 8'h00);
      evt(8'h5a, 2'h3, 10'h001, 4'h8, 6'h00, 8'h04, 8'h04);
      $display("test clear done");
      evt(8'h30, 2'h2, 10'h2c3, 4'h8, 6'h00, 8'h02, 8'h02);
      evt(8'h5a, 2'h2, 10'h2c3, 4'h1, 6'h04, 8'h65, 8'h41);
      evt(8'h5a, 2'h2, 10'h2c3, 4'h1, 6'h06, 8'h65, 8'h21);
      evt(8'h5a, 2'h2, 10'h0c3, 4'h1, 6'h04, 8'h61, 8'h20);
      $display("test factory done");
      foreach (cds[i]) if (i > 13) evt(cds[i], 2'h0, 10'h0, 4'h2, 6'h0, 8'h08, 8'h08);
      evt(8'hd0, 2'h0, 10'h0, 4'h2, 6'h0, 8'h08, 8'h08);
      $display("test lock done");
      repeat (400) begin
         k = ($urandom % 4 == 0) ? 8'($urandom) : cds[$urandom % 17];
         wr(k, 2'($urandom), 10'($urandom), 4'h1 << ($urandom % 4), 6'($urandom) & 6'h3b);
         if ($urandom % 3 == 0) begin
            i_fomx_host_model.idle();
            check("sel", part_sel, exp);
         end
      end
      $display("test random done");
      summarize();
   end
endmodule // fomx_next_state_tb_top
